//--- common/msfr_pkg.sv
package msfr_pkg;

    // ********************************************************
    // Register offsets (byte index on the SFR map).
    // ********************************************************
    localparam logic [7:0] OFS_PORT0 = 8'h80;
    localparam logic [7:0] OFS_SP = 8'h81;
    localparam logic [7:0] OFS_DPL = 8'h82;
    localparam logic [7:0] OFS_DPH = 8'h83;
    localparam logic [7:0] OFS_PWR = 8'h87;
    localparam logic [7:0] OFS_TCTL = 8'h88;
    localparam logic [7:0] OFS_TMODE = 8'h89;
    localparam logic [7:0] OFS_TL0 = 8'h8a;
    localparam logic [7:0] OFS_TL1 = 8'h8b;
    localparam logic [7:0] OFS_TH0 = 8'h8c;
    localparam logic [7:0] OFS_TH1 = 8'h8d;
    localparam logic [7:0] OFS_PORT1 = 8'h90;
    localparam logic [7:0] OFS_BPB1H = 8'h92;
    localparam logic [7:0] OFS_BPB1L = 8'h93;
    localparam logic [7:0] OFS_BPA2H = 8'h94;
    localparam logic [7:0] OFS_BPA2L = 8'h95;
    localparam logic [7:0] OFS_BPA3H = 8'h96;
    localparam logic [7:0] OFS_BPA3L = 8'h97;
    localparam logic [7:0] OFS_SCTL = 8'h98;
    localparam logic [7:0] OFS_SDATA = 8'h99;
    localparam logic [7:0] OFS_PORT2 = 8'ha0;
    localparam logic [7:0] OFS_LPB1H = 8'ha1;
    localparam logic [7:0] OFS_LPB1L = 8'ha2;
    localparam logic [7:0] OFS_LPA2H = 8'ha3;
    localparam logic [7:0] OFS_LPA2L = 8'ha4;
    localparam logic [7:0] OFS_DECIM = 8'ha5;
    localparam logic [7:0] OFS_ONAH = 8'ha6;
    localparam logic [7:0] OFS_ONAL = 8'ha7;
    localparam logic [7:0] OFS_IEN1 = 8'ha8;
    localparam logic [7:0] OFS_PORT3 = 8'hb0;
    localparam logic [7:0] OFS_IPR1 = 8'hb8;
    localparam logic [7:0] OFS_PSW = 8'hd0;
    localparam logic [7:0] OFS_ACC = 8'he0;
    localparam logic [7:0] OFS_IEN2 = 8'he8;
    localparam logic [7:0] OFS_BREG = 8'hf0;
    localparam logic [7:0] OFS_IPR2 = 8'hf8;
    // Block-own event status and mask registers.
    localparam logic [7:0] OFS_EVT_STAT = 8'hfc;
    localparam logic [7:0] OFS_EVT_MASK = 8'hfd;

    // ********************************************************
    // Reset values and field layouts.
    // ********************************************************
    localparam logic [7:0] RST_PORT = 8'hff;
    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam logic [7:0] MASK_IEN1 = 8'h3f;
    localparam logic [7:0] MASK_IEN2 = 8'h7f;
    localparam logic [7:0] MASK_PWR = 8'h0f;
    localparam logic [7:0] MASK_LP_HI = 8'h7f;
    localparam logic [7:0] MASK_DECIM = 8'h3f;
    localparam logic [7:0] MASK_ONA_HI = 8'h07;
    localparam logic [7:0] MASK_EVT = 8'h07;
    localparam int TC_IT0 = 0;
    localparam int TC_IE0 = 1;
    localparam int TC_IT1 = 2;
    localparam int TC_IE1 = 3;
    localparam int TC_TR0 = 4;
    localparam int TC_TF0 = 5;
    localparam int TC_TR1 = 6;
    localparam int TM_TIMER_ZERO_COUNT_SEL = 2;
    localparam int TM_TIMER_ZERO_GATING = 3;
    localparam int TM_TIMER_ONE_COUNT_SEL = 6;
    localparam int P3_LIN_RX = 2;
    localparam int P3_LIN_RXN = 3;
    localparam int P3_GENERAL_PIN_ONE = 4;
    localparam int EV_EXT0 = 0;
    localparam int EV_EXT1 = 1;
    localparam int EV_TOVF = 2;
    localparam int NUM_REGS = 38;

    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [7:0] adr;
        logic [7:0] dat;
    } msfr_wb_req_t;

endpackage : msfr_pkg

//--- rtl/msfr_bank.sv
// Functional notes
// - Port 3 bit 2 carries LIN receive; external interrupt zero on low level.
// - Port 3 bit 3 carries inverted LIN receive; interrupt one on low level.
// - Port 3 bit 4 is general pin one and timer zero count input.
// - Volatile program variables live in static RAM, lost at power down.
// - Code comes from one-time memory; calibration from erasable memory.
// - First enable register: ext0, timer0, ext1, timer1, serial, source five.
// - Second enable register holds enables for sources six to twelve.
// - Priority registers give one priority bit per interrupt source.
// - Timer control exposes run bits, overflow flag, type and pending flags.
// - Timer mode gives per-timer mode, counter select and timer zero gate.
module msfr_bank
    import msfr_pkg::*;
(
    input wire logic CLK_SYS,
    input wire logic SYS_RST,
    input wire logic CLK_EN,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [7:0] WB_ADR_I,
    input wire logic [7:0] WB_DAT_I,
    input wire logic WB_SEL_I,
    output logic [7:0] WB_DAT_O,
    output logic WB_ACK_O,
    output logic WB_ERR_O,
    input wire logic LIN_RX,
    input wire logic LIN_RX_N,
    input wire logic GENERAL_PIN_ONE,
    input wire logic TIMER_ZERO_TICK,
    output logic [7:0] PORT0_O,
    output logic [7:0] PORT1_O,
    output logic [7:0] PORT2_O,
    output logic [7:0] PORT3_O,
    output logic TIMER_ZERO_CNT_IN,
    output logic [7:0] TIMER_CTRL_O,
    output logic [7:0] TIMER_MODE_O,
    output logic [7:0] IEN1_O,
    output logic [7:0] IEN2_O,
    output logic [7:0] IPR1_O,
    output logic [7:0] IPR2_O,
    output logic IRQ
);

    // ********************************************************
    // Register array and address decode.
    // ********************************************************
    // The processor's working RAM and program memories sit outside this bank.
    // volatile storage outside
    localparam logic [7:0] REG_OFS [NUM_REGS] = '{
        OFS_PORT0, OFS_SP, OFS_DPL, OFS_DPH, OFS_PWR, OFS_TCTL, OFS_TMODE,
        OFS_TL0, OFS_TL1, OFS_TH0, OFS_TH1, OFS_PORT1, OFS_BPB1H, OFS_BPB1L,
        OFS_BPA2H, OFS_BPA2L, OFS_BPA3H, OFS_BPA3L, OFS_SCTL, OFS_SDATA,
        OFS_PORT2, OFS_LPB1H, OFS_LPB1L, OFS_LPA2H, OFS_LPA2L, OFS_DECIM,
        OFS_ONAH, OFS_ONAL, OFS_IEN1, OFS_PORT3, OFS_IPR1, OFS_PSW, OFS_ACC,
        OFS_IEN2, OFS_BREG, OFS_IPR2, OFS_EVT_STAT, OFS_EVT_MASK};
    localparam int IX_PORT0 = 0;
    localparam int IX_TCTL = 5;
    localparam int IX_TMODE = 6;
    localparam int IX_PORT1 = 11;
    localparam int IX_PORT2 = 20;
    localparam int IX_IEN1 = 28;
    localparam int IX_PORT3 = 29;
    localparam int IX_IPR1 = 30;
    localparam int IX_IEN2 = 33;
    localparam int IX_IPR2 = 35;
    localparam int IX_STAT = 36;
    localparam int IX_MASK = 37;

    function automatic logic is_port(input logic [7:0] ofs);
        is_port = (ofs == OFS_PORT0) || (ofs == OFS_PORT1) ||
                  (ofs == OFS_PORT2) || (ofs == OFS_PORT3);
    endfunction : is_port

    // Writable bits per register; reserved bits stay zero.
    function automatic logic [7:0] wmask(input logic [7:0] ofs);
        case (ofs)
            OFS_PWR: wmask = MASK_PWR;
            OFS_IEN1, OFS_IPR1: wmask = MASK_IEN1;
            OFS_IEN2, OFS_IPR2: wmask = MASK_IEN2;
            OFS_LPB1H, OFS_LPA2H: wmask = MASK_LP_HI;
            OFS_DECIM: wmask = MASK_DECIM;
            OFS_ONAH: wmask = MASK_ONA_HI;
            OFS_EVT_MASK: wmask = MASK_EVT;
            default: wmask = 8'hff;
        endcase
    endfunction : wmask

    logic [7:0] regs_q [NUM_REGS];
    logic [7:0] regs_d [NUM_REGS];
    logic [NUM_REGS-1:0] hit;
    logic req;
    logic ack_q;
    logic ack_d;
    logic [7:0] rdat_q;
    logic [7:0] rdat_d;
    logic err_q;
    logic err_d;

    assign req = WB_CYC_I && WB_STB_I && !ack_q && !err_q;

    genvar gi;
    generate
        for (gi = 0; gi < NUM_REGS; gi++) begin : g_dec
            assign hit[gi] = (WB_ADR_I == REG_OFS[gi]);
        end
    endgenerate

    // ********************************************************
    // Pin synchronisers.
    // ********************************************************
    logic [2:0] pin_s1_q;
    logic [2:0] pin_s2_q;
    logic [2:0] pin_s3_q;

    always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
        if (SYS_RST) begin
            pin_s1_q <= 3'h7;
            pin_s2_q <= 3'h7;
            pin_s3_q <= 3'h7;
        end else if (CLK_EN) begin
            pin_s1_q <= {GENERAL_PIN_ONE, LIN_RX_N, LIN_RX};
            pin_s2_q <= pin_s1_q;
            pin_s3_q <= pin_s2_q;
        end
    end

    logic lin_rx_s;
    logic lin_rxn_s;
    logic general_pin_one_s;
    assign lin_rx_s = pin_s2_q[0];
    assign lin_rxn_s = pin_s2_q[1];
    assign general_pin_one_s = pin_s2_q[2];

    // ********************************************************
    // External interrupt and timer zero overflow detection.
    // ********************************************************
    logic [7:0] tctl;
    logic ext0_evt;
    logic ext1_evt;
    logic tovf_evt;
    assign tctl = regs_q[IX_TCTL];
    assign ext0_evt = tctl[TC_IT0] ? (pin_s3_q[0] && !lin_rx_s) : !lin_rx_s;
    assign ext1_evt = tctl[TC_IT1] ? (pin_s3_q[1] && !lin_rxn_s) : !lin_rxn_s;
    assign tovf_evt = TIMER_ZERO_TICK && tctl[TC_TR0];

    // ********************************************************
    // Register next-state.
    // ********************************************************
    logic wr;
    logic [7:0] wd;

    always_comb begin
        wr = req && WB_WE_I && WB_SEL_I;
        wd = WB_DAT_I & wmask(WB_ADR_I);
        for (int i = 0; i < NUM_REGS; i++) begin
            regs_d[i] = regs_q[i];
            if (wr && hit[i]) begin
                regs_d[i] = (i == IX_STAT) ? (regs_q[i] & ~wd) : wd;
            end
        end
        // Port 3 inputs reflect the pins; the pin value overrides any value written to those bits.
        // LIN receive on bit 2
        regs_d[IX_PORT3][P3_LIN_RX] = lin_rx_s;
        regs_d[IX_PORT3][P3_LIN_RXN] = lin_rxn_s;
        // general pin one on bit 4
        regs_d[IX_PORT3][P3_GENERAL_PIN_ONE] = general_pin_one_s;
        // hardware sets pending flags; set wins over write
        if (ext0_evt) begin
            regs_d[IX_TCTL][TC_IE0] = 1'b1;
        end
        if (ext1_evt) begin
            regs_d[IX_TCTL][TC_IE1] = 1'b1;
        end
        if (tovf_evt) begin
            regs_d[IX_TCTL][TC_TF0] = 1'b1;
        end
        regs_d[IX_TCTL][7] = 1'b0;
        // Sticky event status: set beats a write-one clear.
        regs_d[IX_STAT][EV_EXT0] = regs_d[IX_STAT][EV_EXT0] | ext0_evt;
        regs_d[IX_STAT][EV_EXT1] = regs_d[IX_STAT][EV_EXT1] | ext1_evt;
        regs_d[IX_STAT][EV_TOVF] = regs_d[IX_STAT][EV_TOVF] | tovf_evt;
    end

    always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
        if (SYS_RST) begin
            for (int i = 0; i < NUM_REGS; i++) begin
                regs_q[i] <= is_port(REG_OFS[i]) ? RST_PORT : RST_ZERO;
            end
        end else if (CLK_EN) begin
            regs_q <= regs_d;
        end
    end

    // ********************************************************
    // Wishbone answer.
    // ********************************************************
    always_comb begin
        ack_d = 1'b0;
        err_d = 1'b0;
        rdat_d = rdat_q;
        if (req) begin
            if (|hit) begin
                ack_d = 1'b1;
                rdat_d = 8'h00;
                for (int i = 0; i < NUM_REGS; i++) begin
                    if (hit[i]) begin
                        rdat_d = regs_q[i];
                    end
                end
            end else begin
                err_d = 1'b1;
                rdat_d = 8'h00;
            end
        end
    end

    always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
        if (SYS_RST) begin
            ack_q <= 1'b0;
            err_q <= 1'b0;
            rdat_q <= 8'h00;
        end else if (CLK_EN) begin
            ack_q <= ack_d;
            err_q <= err_d;
            rdat_q <= rdat_d;
        end
    end

    // ********************************************************
    // Outputs.
    // ********************************************************
    assign WB_ACK_O = ack_q;
    assign WB_ERR_O = err_q;
    assign WB_DAT_O = rdat_q;
    assign PORT0_O = regs_q[IX_PORT0];
    assign PORT1_O = regs_q[IX_PORT1];
    assign PORT2_O = regs_q[IX_PORT2];
    assign PORT3_O = regs_q[IX_PORT3];
    assign TIMER_ZERO_CNT_IN = regs_q[IX_PORT3][P3_GENERAL_PIN_ONE];
    assign TIMER_CTRL_O = regs_q[IX_TCTL];
    assign TIMER_MODE_O = regs_q[IX_TMODE];
    assign IEN1_O = regs_q[IX_IEN1];
    assign IEN2_O = regs_q[IX_IEN2];
    assign IPR1_O = regs_q[IX_IPR1];
    assign IPR2_O = regs_q[IX_IPR2];
    assign IRQ = |(regs_q[IX_STAT] & regs_q[IX_MASK]);

    // ********************************************************
    // Checks.
    // ********************************************************
    chk_ext0_pending: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
        (CLK_EN && !tctl[TC_IT0] && !lin_rx_s) |=> tctl[TC_IE0])
        else $error("ext0 pending not set on low line");
    chk_ext1_pending: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
        (CLK_EN && !tctl[TC_IT1] && !lin_rxn_s) |=> tctl[TC_IE1])
        else $error("ext1 pending not set on low line");
    chk_gpio_count: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
        CLK_EN |-> ##1 (TIMER_ZERO_CNT_IN == $past(general_pin_one_s)))
        else $error("timer count input does not follow pin");
    chk_ien1_write: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
        (CLK_EN && wr && WB_ADR_I == OFS_IEN1) |=> (IEN1_O == ($past(WB_DAT_I) & MASK_IEN1)))
        else $error("first enable write wrong");
    chk_ien2_write: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
        (CLK_EN && wr && WB_ADR_I == OFS_IEN2) |=> (IEN2_O == ($past(WB_DAT_I) & MASK_IEN2)))
        else $error("second enable write wrong");
    chk_prio_hold: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
        !(wr && (hit[IX_IPR1] || hit[IX_IPR2])) |=> $stable(IPR1_O) && $stable(IPR2_O))
        else $error("priority changed without write");
    chk_tovf_flag: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
        (CLK_EN && tovf_evt) |=> TIMER_CTRL_O[TC_TF0] && regs_q[IX_STAT][EV_TOVF])
        else $error("overflow flag not set");
    chk_tmode_write: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
        (CLK_EN && wr && WB_ADR_I == OFS_TMODE) |=> (TIMER_MODE_O == $past(WB_DAT_I)))
        else $error("timer mode write wrong");
    chk_ack_pulse: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
        (CLK_EN && WB_ACK_O) |=> !WB_ACK_O)
        else $error("ack held longer than one cycle");

endmodule : msfr_bank

//--- tb/msfr_cpu_model.sv
// ********************************************************
// Processor-side bus master for the register bank.
// ********************************************************
module msfr_cpu_model
    import msfr_pkg::*;
(
    input wire logic clk,
    input wire logic ack,
    input wire logic err,
    input wire logic [7:0] rdat,
    output msfr_wb_req_t req,
    output logic sel
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        req = '0;
        sel = 1'b0;
    end

    // The request stands until ack or err is seen or 16 cycles pass; ok tells which happened.
    task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d, input logic s,
                          output logic [7:0] q, output logic e, output logic ok);
        int n;
        ok = 1'b0;
        q = 8'h00;
        e = 1'b0;
        @(posedge clk);
        req <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: a, dat: d};
        sel <= s;
        for (n = 0; n < 16; n++) begin
            @(posedge clk);
            if (ack === 1'b1 || err === 1'b1) begin
                q = rdat;
                e = err;
                ok = 1'b1;
                break;
            end
        end
        req <= '0;
    endtask : access
endmodule : msfr_cpu_model

//--- tb/msfr_bank_test.sv
module msfr_bank_test
    import msfr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic lin_rx = 1'b1;
    logic lin_rx_n = 1'b1;
    logic gpin = 1'b1;
    logic tick = 1'b0;
    logic clk_en = 1'b1;
    msfr_wb_req_t wb_req;
    logic wb_sel, ack, err, irq, cnt_in;
    logic [7:0] rdat, p0, p1, p2, p3, tctl, tmode, ien1, ien2, ipr1, ipr2;
    int num_errors = 0;
    int checks_done = 0;
    logic [7:0] regs [38] = '{8'h80, 8'h81, 8'h82, 8'h83, 8'h87, 8'h88, 8'h89, 8'h8a, 8'h8b, 8'h8c,
        8'h8d, 8'h90, 8'h92, 8'h93, 8'h94, 8'h95, 8'h96, 8'h97, 8'h98, 8'h99, 8'ha0, 8'ha1, 8'ha2,
        8'ha3, 8'ha4, 8'ha5, 8'ha6, 8'ha7, 8'ha8, 8'hb0, 8'hb8, 8'hd0, 8'he0, 8'he8, 8'hf0, 8'hf8,
        8'hfc, 8'hfd};

    always #10 clk_sys = ~clk_sys;

    msfr_bank i_dut (.CLK_SYS(clk_sys), .SYS_RST(sys_rst), .CLK_EN(clk_en), .WB_CYC_I(wb_req.cyc),
        .WB_STB_I(wb_req.stb), .WB_WE_I(wb_req.we), .WB_ADR_I(wb_req.adr), .WB_DAT_I(wb_req.dat),
        .WB_SEL_I(wb_sel), .WB_DAT_O(rdat), .WB_ACK_O(ack), .WB_ERR_O(err), .LIN_RX(lin_rx),
        .LIN_RX_N(lin_rx_n), .GENERAL_PIN_ONE(gpin), .TIMER_ZERO_TICK(tick), .PORT0_O(p0),
        .PORT1_O(p1), .PORT2_O(p2), .PORT3_O(p3), .TIMER_ZERO_CNT_IN(cnt_in), .TIMER_CTRL_O(tctl),
        .TIMER_MODE_O(tmode), .IEN1_O(ien1), .IEN2_O(ien2), .IPR1_O(ipr1), .IPR2_O(ipr2), .IRQ(irq));

    msfr_cpu_model i_cpu (.clk(clk_sys), .ack(ack), .err(err), .rdat(rdat), .req(wb_req), .sel(wb_sel));

    // ********************************************************
    // Shared checking and bus tasks.
    // ********************************************************
    task automatic results();
        $display("checks %0d, mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : results

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value at %0t ns: seen 0x%h expected 0x%h", $time, seen, exp);
        end
    endtask : chk

    task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d, input logic s,
                        output logic [7:0] q, output logic e);
        logic ok;
        i_cpu.access(w, a, d, s, q, e, ok);
        if (!ok) begin
            num_errors++;
            $display("bus answer missing at %0t ns", $time);
            results();
        end
    endtask : xfer

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] q;
        logic e;
        xfer(1'b1, a, d, 1'b1, q, e);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] q;
        logic e;
        xfer(1'b0, a, 8'h00, 1'b1, q, e);
        chk(q, exp);
    endtask : rd

    function automatic logic [7:0] wmask(input logic [7:0] a);
        case (a)
            OFS_PWR: return MASK_PWR;
            OFS_IEN1, OFS_IPR1: return MASK_IEN1;
            OFS_IEN2, OFS_IPR2: return MASK_IEN2;
            OFS_LPB1H, OFS_LPA2H: return MASK_LP_HI;
            OFS_DECIM: return MASK_DECIM;
            OFS_ONAH: return MASK_ONA_HI;
            OFS_EVT_MASK: return MASK_EVT;
            default: return 8'hff;
        endcase
    endfunction : wmask

    // ********************************************************
    // Scenarios.
    // ********************************************************
    task automatic test_reset();
        foreach (regs[i]) rd(regs[i], (regs[i][3:0] == 4'h0 && regs[i] < 8'hc0) ? 8'hff : 8'h00);
        chk({7'h0, irq}, 8'h00);
        $display("reset values done");
    endtask : test_reset

    // Both interrupt pins share one walk; k selects receive or inverted receive.
    task automatic test_pin_evt(input int k);
        if (k == 0) lin_rx <= 1'b0;
        else lin_rx_n <= 1'b0;
        repeat (5) @(posedge clk_sys);
        chk(p3, ~(8'h04 << k));
        rd(OFS_TCTL, 8'h02 << (2 * k));
        rd(OFS_EVT_STAT, 8'h01 << k);
        wr(OFS_EVT_MASK, 8'h01 << k);
        repeat (2) @(posedge clk_sys);
        chk({7'h0, irq}, 8'h01);
        wr(OFS_EVT_MASK, 8'h00);
        repeat (2) @(posedge clk_sys);
        chk({7'h0, irq}, 8'h00);
        lin_rx <= 1'b1;
        lin_rx_n <= 1'b1;
        repeat (5) @(posedge clk_sys);
        wr(OFS_TCTL, 8'h00);
        wr(OFS_EVT_STAT, MASK_EVT);
        rd(OFS_EVT_STAT, 8'h00);
        rd(OFS_TCTL, 8'h00);
        wr(OFS_TCTL, 8'h01 << (2 * k));
        if (k == 0) lin_rx <= 1'b0;
        else lin_rx_n <= 1'b0;
        repeat (5) @(posedge clk_sys);
        rd(OFS_TCTL, 8'h03 << (2 * k));
        wr(OFS_TCTL, 8'h01 << (2 * k));
        wr(OFS_EVT_STAT, MASK_EVT);
        rd(OFS_TCTL, 8'h01 << (2 * k));
        rd(OFS_EVT_STAT, 8'h00);
        lin_rx <= 1'b1;
        lin_rx_n <= 1'b1;
        repeat (5) @(posedge clk_sys);
        wr(OFS_TCTL, 8'h00);
        rd(OFS_TCTL, 8'h00);
        $display("pin event %0d done", k);
    endtask : test_pin_evt

    task automatic test_gpio();
        clk_en <= 1'b0;
        gpin <= 1'b0;
        repeat (5) @(posedge clk_sys);
        chk(p3, 8'hff);
        clk_en <= 1'b1;
        repeat (5) @(posedge clk_sys);
        chk(p3, 8'hef);
        chk({7'h0, cnt_in}, 8'h00);
        gpin <= 1'b1;
        repeat (5) @(posedge clk_sys);
        chk({7'h0, cnt_in}, 8'h01);
        $display("general pin done");
    endtask : test_gpio

    task automatic pulse_tick();
        @(posedge clk_sys);
        tick <= 1'b1;
        @(posedge clk_sys);
        tick <= 1'b0;
    endtask : pulse_tick

    task automatic test_timer();
        pulse_tick();
        rd(OFS_TCTL, 8'h00);
        rd(OFS_EVT_STAT, 8'h00);
        wr(OFS_TCTL, 8'h10);
        pulse_tick();
        rd(OFS_TCTL, 8'h30);
        chk(tctl, 8'h30);
        rd(OFS_EVT_STAT, 8'h04);
        wr(OFS_TCTL, 8'h00);
        wr(OFS_EVT_STAT, 8'h04);
        rd(OFS_EVT_STAT, 8'h00);
        $display("timer overflow done");
    endtask : test_timer

    task automatic test_rw();
        logic [7:0] q;
        logic e;
        foreach (regs[i]) begin
            if (regs[i] != OFS_TCTL && regs[i] != OFS_EVT_STAT) begin
                wr(regs[i], 8'hff);
                rd(regs[i], wmask(regs[i]));
            end
        end
        chk(ien1, MASK_IEN1);
        chk(ien2, MASK_IEN2);
        chk(ipr1, MASK_IEN1);
        chk(ipr2, MASK_IEN2);
        chk(tmode, 8'hff);
        chk(p0 & p1 & p2 & p3, 8'hff);
        xfer(1'b1, OFS_ACC, 8'h00, 1'b0, q, e);
        rd(OFS_ACC, 8'hff);
        wr(OFS_TMODE, 8'h00);
        chk(tmode, 8'h00);
        foreach (regs[i]) begin
            xfer(1'b0, regs[i] ^ 8'h04 ^ {7'h0, regs[i][2]}, 8'h00, 1'b1, q, e);
        end
        xfer(1'b1, 8'h84, 8'h5a, 1'b1, q, e);
        chk({7'h0, e}, 8'h01);
        xfer(1'b0, 8'h91, 8'h00, 1'b1, q, e);
        chk({7'h0, e}, 8'h01);
        $display("read write done");
    endtask : test_rw

    task automatic test_midrst();
        sys_rst <= 1'b1;
        repeat (3) @(posedge clk_sys);
        chk(ien1, 8'h00);
        sys_rst <= 1'b0;
        repeat (2) @(posedge clk_sys);
        rd(OFS_IEN1, 8'h00);
        rd(OFS_TMODE, 8'h00);
        rd(OFS_EVT_MASK, 8'h00);
        rd(OFS_PORT2, 8'hff);
        chk({7'h0, irq}, 8'h00);
        $display("mid-run reset done");
    endtask : test_midrst

    initial begin
        repeat (12) @(posedge clk_sys);
        sys_rst <= 1'b0;
        repeat (6) @(posedge clk_sys);
        test_reset();
        test_pin_evt(0);
        test_pin_evt(1);
        test_gpio();
        test_timer();
        test_rw();
        test_midrst();
        results();
    end
endmodule : msfr_bank_test
